/* logic/clk_xlat_regs_pkg.sv */
// Constants for the loop configuration and interrupt mask register bank.
// Assumes a 125 MHz system clock and APB access with one byte per aligned word.
package clk_xlat_regs_pkg;

	// Slot numbers in the register file
	localparam int NSLOT  = 22;
	localparam int NCFG   = 18;
	localparam int NSTAT  = 4;
	localparam int S_AUX  = 0;
	localparam int S_LOOP = 1;
	localparam int S_HLIM = 2;
	localparam int S_REF  = 3;
	localparam int S_RSV  = 4;
	localparam int S_WDL  = 5;
	localparam int S_WDH  = 6;
	localparam int S_FR0  = 7;
	localparam int S_FR1  = 8;
	localparam int S_FR2  = 9;
	localparam int S_FR3  = 10;
	localparam int S_OSC  = 11;
	localparam int S_CL0  = 12;
	localparam int S_CL1  = 13;
	localparam int S_CL2  = 14;
	localparam int S_CU0  = 15;
	localparam int S_CU1  = 16;
	localparam int S_CU2  = 17;
	localparam int S_ST0  = 18;

	// Register index per slot; the byte address is four times the index
	localparam logic [11:0] SLOT_IDX [NSLOT] = '{
		12'h20b, 12'h20c, 12'h20d, 12'h20e, 12'h20f, 12'h210, 12'h211,
		12'h300, 12'h301, 12'h302, 12'h303, 12'h304,
		12'h306, 12'h307, 12'h308, 12'h309, 12'h30a, 12'h30b,
		12'hd02, 12'hd03, 12'hd04, 12'hd05};

	// Reset value per slot
	localparam logic [7:0] SLOT_RST [NSLOT] = '{
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h11, 8'h15, 8'h64, 8'h1b, 8'h00,
		8'h51, 8'hb8, 8'h02, 8'h3e, 8'h0a, 8'h0b,
		8'h00, 8'h00, 8'h00, 8'h00};

	// Implemented bits per slot; the rest read as zero
	localparam logic [7:0] SLOT_WMASK [NSLOT] = '{
		8'h1f, 8'hff, 8'h1f, 8'h77, 8'h00, 8'hff, 8'hff,
		8'hff, 8'hff, 8'hff, 8'h3f, 8'h20,
		8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h0f,
		8'h1f, 8'hff, 8'h1f, 8'h77};

	localparam logic [4:0] SLOT_NONE = 5'h1f;

	// Field positions
	localparam int AUX_WDOG_BIT  = 2;
	localparam int OSC_4LVL_BIT  = 5;

	// Watchdog time base
	localparam int WDOG_UNIT_MS    = 1;
	localparam int CLK_HZ          = 125_000_000;
	localparam int WDOG_CYC_PER_MS = CLK_HZ / 1000 * WDOG_UNIT_MS;

endpackage

/* logic/clk_xlat_regs.sv */
// Register bank for the loop: interrupt masks and sticky status, watchdog
// interval and timer, free-run word, oscillator mode and pull-in clamps.
// Assumes an APB master on clk_sys and event pulses from logic on clk_sys.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module clk_xlat_regs #(
	parameter int unsigned CYC_PER_MS = clk_xlat_regs_pkg::WDOG_CYC_PER_MS
) (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [13:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [4:0]  aux_events,
	input  wire logic [7:0]  loop_events,
	input  wire logic [4:0]  limiter_events,
	input  wire logic [6:0]  reference_events,
	input  wire logic        watchdog_kick,
	output logic             irq,
	output logic             watchdog_expired,
	output logic [15:0]      watchdog_interval,
	output logic [29:0]      free_run_word,
	output logic             digital_oscillator_four_level,
	output logic [19:0]      clamp_lower,
	output logic [19:0]      clamp_upper
);

	// Address to slot; read and write share the same decode
	function automatic logic [4:0] slot_of(input logic [13:0] addr);
		logic [4:0] res;
		res = clk_xlat_regs_pkg::SLOT_NONE;
		for (int i = 0; i < clk_xlat_regs_pkg::NSLOT; i++) begin
			if (addr[1:0] == 2'h0 && addr[13:2] == clk_xlat_regs_pkg::SLOT_IDX[i]) begin
				res = 5'(i);
			end
		end
		return res;
	endfunction

	logic [7:0]  rf_r [clk_xlat_regs_pkg::NSLOT];
	logic [7:0]  rf_nxt [clk_xlat_regs_pkg::NSLOT];
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;
	logic        irq_r;
	logic        wdog_exp_r;
	logic [16:0] ms_cnt_r;
	logic [15:0] ms_elapsed_r;

	// Bus decode and handshake terms
	wire logic [4:0] sel_slot  = slot_of(paddr);
	wire logic       sel_valid = sel_slot != clk_xlat_regs_pkg::SLOT_NONE;
	wire logic       setup     = psel && !penable;
	wire logic       fire      = psel && penable && pready_r;
	wire logic       wr_fire   = fire && pwrite && pstrb[0] && sel_valid;
	wire logic       rd_fire   = fire && !pwrite;
	wire logic [7:0] rd_byte   = sel_valid ? rf_r[sel_slot] : 8'h00;

	// Events as seen by the status slots; watchdog expiry joins the aux group
	wire logic [7:0] ev_vec [clk_xlat_regs_pkg::NSTAT];
	assign ev_vec[0] = {3'h0, aux_events[4:3],
		aux_events[clk_xlat_regs_pkg::AUX_WDOG_BIT] | wdog_exp_r, aux_events[1:0]};
	assign ev_vec[1] = loop_events;
	assign ev_vec[2] = {3'h0, limiter_events};
	assign ev_vec[3] = {1'b0, reference_events};

	// Register file: config slots take writes, status slots are write-one-to-clear
	for (genvar s = 0; s < clk_xlat_regs_pkg::NSLOT; s++) begin : g_slot
		wire logic       hit = wr_fire && sel_slot == 5'(s);
		wire logic [7:0] wm  = clk_xlat_regs_pkg::SLOT_WMASK[s];
		if (s < clk_xlat_regs_pkg::NCFG) begin : g_cfg
			assign rf_nxt[s] = hit ? (pwdata[7:0] & wm) : rf_r[s];
		end else begin : g_stat
			// mask gates recording; set wins over clear
			wire logic [7:0] clr = hit ? (pwdata[7:0] & wm) : 8'h00;
			wire logic [7:0] set = ev_vec[s - clk_xlat_regs_pkg::NCFG]
				& rf_r[s - clk_xlat_regs_pkg::NCFG] & wm;
			assign rf_nxt[s] = (rf_r[s] & ~clr) | set;
		end
		always_ff @(posedge clk_sys or posedge sys_rst) begin
			if (sys_rst) begin
				rf_r[s] <= clk_xlat_regs_pkg::SLOT_RST[s];
			end else begin
				rf_r[s] <= rf_nxt[s];
			end
		end
	end

	// APB slave: one wait-free access phase; read data captured in setup
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			pready_r <= setup;
			if (setup) begin
				pslverr_r <= !sel_valid;
				prdata_r  <= {24'h00_0000, rd_byte};
			end
		end
	end

	// Watchdog time base; any interval change or kick restarts the count
	wire logic [15:0] wd_int  = {rf_r[clk_xlat_regs_pkg::S_WDH], rf_r[clk_xlat_regs_pkg::S_WDL]};
	wire logic        wd_rst  = watchdog_kick || (wr_fire &&
		(sel_slot == 5'(clk_xlat_regs_pkg::S_WDL) || sel_slot == 5'(clk_xlat_regs_pkg::S_WDH)));
	wire logic        ms_tick = ms_cnt_r == 17'(CYC_PER_MS - 1);
	wire logic        wd_on   = wd_int != 16'h0000;
	wire logic        wd_fire = wd_on && !wd_rst && ms_tick && (ms_elapsed_r + 16'h0001 == wd_int);

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ms_cnt_r     <= 17'h0_0000;
			ms_elapsed_r <= 16'h0000;
			wdog_exp_r   <= 1'b0;
		end else begin
			wdog_exp_r <= wd_fire;
			if (!wd_on || wd_rst || ms_tick) begin
				ms_cnt_r <= 17'h0_0000;
			end else begin
				ms_cnt_r <= ms_cnt_r + 17'h0_0001;
			end
			if (!wd_on || wd_rst || wd_fire) begin
				ms_elapsed_r <= 16'h0000;
			end else if (ms_tick) begin
				ms_elapsed_r <= ms_elapsed_r + 16'h0001;
			end
		end
	end

	// Level interrupt while any recorded event is still enabled
	wire logic pending = |(rf_r[clk_xlat_regs_pkg::S_ST0] & rf_r[clk_xlat_regs_pkg::S_AUX])
		| |(rf_r[clk_xlat_regs_pkg::S_ST0 + 1] & rf_r[clk_xlat_regs_pkg::S_LOOP])
		| |(rf_r[clk_xlat_regs_pkg::S_ST0 + 2] & rf_r[clk_xlat_regs_pkg::S_HLIM])
		| |(rf_r[clk_xlat_regs_pkg::S_ST0 + 3] & rf_r[clk_xlat_regs_pkg::S_REF]);

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= pending;
		end
	end

	// Outputs straight from the register flops
	assign prdata            = prdata_r;
	assign pready            = pready_r;
	assign pslverr           = pslverr_r;
	assign irq               = irq_r;
	assign watchdog_expired  = wdog_exp_r;
	assign watchdog_interval = wd_int;
	assign free_run_word = {rf_r[clk_xlat_regs_pkg::S_FR3][5:0], rf_r[clk_xlat_regs_pkg::S_FR2],
		rf_r[clk_xlat_regs_pkg::S_FR1], rf_r[clk_xlat_regs_pkg::S_FR0]};
	assign digital_oscillator_four_level = rf_r[clk_xlat_regs_pkg::S_OSC][clk_xlat_regs_pkg::OSC_4LVL_BIT];
	assign clamp_lower = {rf_r[clk_xlat_regs_pkg::S_CL2][3:0], rf_r[clk_xlat_regs_pkg::S_CL1],
		rf_r[clk_xlat_regs_pkg::S_CL0]};
	assign clamp_upper = {rf_r[clk_xlat_regs_pkg::S_CU2][3:0], rf_r[clk_xlat_regs_pkg::S_CU1],
		rf_r[clk_xlat_regs_pkg::S_CU0]};

	// Checks on the bank's behaviour
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	wire logic [7:0] st_aux  = rf_r[clk_xlat_regs_pkg::S_ST0];
	wire logic [7:0] st_loop = rf_r[clk_xlat_regs_pkg::S_ST0 + 1];
	wire logic [7:0] st_hlim = rf_r[clk_xlat_regs_pkg::S_ST0 + 2];
	wire logic [7:0] st_ref  = rf_r[clk_xlat_regs_pkg::S_ST0 + 3];
	wire logic [7:0] mk_aux  = rf_r[clk_xlat_regs_pkg::S_AUX];
	wire logic [7:0] mk_loop = rf_r[clk_xlat_regs_pkg::S_LOOP];
	wire logic [7:0] mk_hlim = rf_r[clk_xlat_regs_pkg::S_HLIM];
	wire logic [7:0] mk_ref  = rf_r[clk_xlat_regs_pkg::S_REF];

	a_aux_rom_end: assert property (
		aux_events[4] && mk_aux[4] |=> st_aux[4])
		else $error("Enabled ROM load end not recorded");
	a_aux_wdog_rec: assert property (
		wdog_exp_r && mk_aux[2] |=> st_aux[2])
		else $error("Enabled watchdog expiry not recorded");
	a_loop_switch: assert property (
		loop_events[7] && mk_loop[7] |=> st_loop[7])
		else $error("Enabled reference switch not recorded");
	a_loop_phase_mask: assert property (
		!mk_loop[0] && !st_loop[0] |=> !st_loop[0])
		else $error("Masked phase lock event recorded");
	a_hist_update: assert property (
		limiter_events[4] && mk_hlim[4] |=> st_hlim[4])
		else $error("Enabled history update not recorded");
	a_clamp_enter: assert property (
		limiter_events[2] && mk_hlim[2] |=> st_hlim[2])
		else $error("Enabled clamp entry not recorded");
	a_slew_stop: assert property (
		limiter_events[1] && mk_hlim[1] |=> st_hlim[1])
		else $error("Enabled slew stop not recorded");
	a_reference_input_a_fault: assert property (
		reference_events[0] && mk_ref[0] |=> st_ref[0])
		else $error("Enabled reference A fault not recorded");
	a_reference_input_b_reserved: assert property (
		wr_fire && sel_slot == 5'(clk_xlat_regs_pkg::S_REF) |=> !mk_ref[7] && !mk_ref[3])
		else $error("Reserved reference mask bits set");
	a_wdog_low_wr: assert property (
		wr_fire && sel_slot == 5'(clk_xlat_regs_pkg::S_WDL)
		|=> watchdog_interval[7:0] == $past(pwdata[7:0]))
		else $error("Watchdog low byte not written");
	a_wdog_off: assert property (
		watchdog_interval == 16'h0000 |=> !watchdog_expired)
		else $error("Watchdog expired while disabled");
	a_free_run_rst: assert property (
		$past(sys_rst) |-> free_run_word == {
		clk_xlat_regs_pkg::SLOT_RST[clk_xlat_regs_pkg::S_FR3][5:0],
		clk_xlat_regs_pkg::SLOT_RST[clk_xlat_regs_pkg::S_FR2],
		clk_xlat_regs_pkg::SLOT_RST[clk_xlat_regs_pkg::S_FR1],
		clk_xlat_regs_pkg::SLOT_RST[clk_xlat_regs_pkg::S_FR0]})
		else $error("Free-run word reset value wrong");
	a_osc_mode_wr: assert property (
		wr_fire && sel_slot == 5'(clk_xlat_regs_pkg::S_OSC)
		|=> digital_oscillator_four_level == $past(pwdata[5]))
		else $error("Oscillator mode not written");
	a_clamp_lo_rd: assert property (
		rd_fire && sel_slot == 5'(clk_xlat_regs_pkg::S_CL2) |-> prdata_r[31:4] == 28'h000_0000)
		else $error("Lower clamp top byte reserved bits set");
	a_clamp_hi_wr: assert property (
		wr_fire && sel_slot == 5'(clk_xlat_regs_pkg::S_CU2)
		|=> clamp_upper[19:16] == $past(pwdata[3:0]))
		else $error("Upper clamp top bits not written");
	a_irq_level: assert property (
		pending |=> irq)
		else $error("Interrupt not raised for enabled event");
	a_rsv_read_zero: assert property (
		rd_fire && sel_slot == 5'(clk_xlat_regs_pkg::S_RSV) |-> prdata_r == 32'h0000_0000)
		else $error("Reserved mask register reads nonzero");

	a_aux_sync: assert property (
		aux_events[3] && mk_aux[3] |=> st_aux[3])
		else $error("Enabled sync event not recorded");

	a_aux_eep_fault: assert property (
		aux_events[1] && mk_aux[1] |=> st_aux[1])
		else $error("Enabled EEPROM fault not recorded");

	a_aux_eep_done: assert property (
		aux_events[0] && mk_aux[0] |=> st_aux[0])
		else $error("Enabled EEPROM done not recorded");

	a_loop_closed: assert property (
		loop_events[6] && mk_loop[6] |=> st_loop[6])
		else $error("Enabled closed loop entry not recorded");

	a_loop_free_run: assert property (
		loop_events[5] && mk_loop[5] |=> st_loop[5])
		else $error("Enabled free run entry not recorded");

	a_loop_holdover: assert property (
		loop_events[4] && mk_loop[4] |=> st_loop[4])
		else $error("Enabled holdover entry not recorded");

	a_loop_freq_loss: assert property (
		loop_events[3] && mk_loop[3] |=> st_loop[3])
		else $error("Enabled frequency unlock not recorded");

	a_loop_freq_gain: assert property (
		loop_events[2] && mk_loop[2] |=> st_loop[2])
		else $error("Enabled frequency lock not recorded");

	a_loop_phase_loss: assert property (
		loop_events[1] && mk_loop[1] |=> st_loop[1])
		else $error("Enabled phase unlock not recorded");

	a_loop_phase_gain: assert property (
		loop_events[0] && mk_loop[0] |=> st_loop[0])
		else $error("Enabled phase lock not recorded");

	a_clamp_leave: assert property (
		limiter_events[3] && mk_hlim[3] |=> st_hlim[3])
		else $error("Enabled clamp exit not recorded");

	a_slew_start: assert property (
		limiter_events[0] && mk_hlim[0] |=> st_hlim[0])
		else $error("Enabled slew start not recorded");

	a_reference_input_a_valid: assert property (
		reference_events[2] && mk_ref[2] |=> st_ref[2])
		else $error("Enabled reference A valid not recorded");

	a_reference_input_a_clear: assert property (
		reference_events[1] && mk_ref[1] |=> st_ref[1])
		else $error("Enabled reference A clear not recorded");

	a_reference_input_b_valid: assert property (
		reference_events[6] && mk_ref[6] |=> st_ref[6])
		else $error("Enabled reference B valid not recorded");

	a_reference_input_b_clear: assert property (
		reference_events[5] && mk_ref[5] |=> st_ref[5])
		else $error("Enabled reference B clear not recorded");

	a_reference_input_b_fault: assert property (
		reference_events[4] && mk_ref[4] |=> st_ref[4])
		else $error("Enabled reference B fault not recorded");

	a_status_sticky: assert property (
		st_aux[4] && !(wr_fire && sel_slot == 5'(clk_xlat_regs_pkg::S_ST0)) |=> st_aux[4])
		else $error("Status bit lost without a clear");

	a_status_w1c: assert property (
		wr_fire && sel_slot == 5'(clk_xlat_regs_pkg::S_ST0) && pwdata[0]
		&& !(aux_events[0] && mk_aux[0]) |=> !st_aux[0])
		else $error("Status bit not cleared by write one");

	a_irq_low: assert property (
		!pending |=> !irq)
		else $error("Interrupt raised with nothing pending");

	a_wdog_high_wr: assert property (
		wr_fire && sel_slot == 5'(clk_xlat_regs_pkg::S_WDH)
		|=> watchdog_interval[15:8] == $past(pwdata[7:0]))
		else $error("Watchdog high byte not written");

	a_free_run_wr: assert property (
		wr_fire && sel_slot == 5'(clk_xlat_regs_pkg::S_FR3)
		|=> free_run_word[29:24] == $past(pwdata[5:0]))
		else $error("Free-run word top bits not written");

	a_osc_rsv_read: assert property (
		rd_fire && sel_slot == 5'(clk_xlat_regs_pkg::S_OSC) |-> prdata_r[4:0] == 5'h00)
		else $error("Oscillator reserved bits read nonzero");

	a_clamp_lo_wr: assert property (
		wr_fire && sel_slot == 5'(clk_xlat_regs_pkg::S_CL0)
		|=> clamp_lower[7:0] == $past(pwdata[7:0]))
		else $error("Lower clamp low byte not written");

	a_unmapped_err: assert property (
		fire && !sel_valid |-> pslverr)
		else $error("Unmapped access without error");

endmodule

`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the loop register bank, driven as an APB master.
// Assumes the bank answers every access phase and keeps one byte per word.
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, err, irq;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic [4:0]  aux_events, limiter_events;
	logic [7:0]  loop_events;
	logic [6:0]  reference_events;
	logic        watchdog_kick, watchdog_expired, four_lvl;
	logic [15:0] wd_int;
	logic [29:0] fr_word;
	logic [19:0] cl_lo, cl_hi;
	logic [7:0]  mdl [clk_xlat_regs_pkg::NSLOT];
	int          fail_count = 0, samples_checked = 0, cyc = 0, exp_cnt = 0, seed, e0, n;

	// Short millisecond keeps watchdog runs brief
	clk_xlat_regs #(.CYC_PER_MS(10)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .aux_events(aux_events),
		.loop_events(loop_events), .limiter_events(limiter_events),
		.reference_events(reference_events), .watchdog_kick(watchdog_kick), .irq(irq),
		.watchdog_expired(watchdog_expired), .watchdog_interval(wd_int),
		.free_run_word(fr_word), .digital_oscillator_four_level(four_lvl),
		.clamp_lower(cl_lo), .clamp_upper(cl_hi));

	task automatic wrap_up();
		if (fail_count == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Request held from setup until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d,
		input logic [3:0] s);
		int k;
		k = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		pstrb <= s;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (k >= 16) fail_count++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input int s, input logic [7:0] d);
		apb(1'b1, clk_xlat_regs_pkg::SLOT_IDX[s], d, 4'h1);
		mdl[s] = d & clk_xlat_regs_pkg::SLOT_WMASK[s];
	endtask

	task automatic rdchk(input int s);
		apb(1'b0, clk_xlat_regs_pkg::SLOT_IDX[s], 8'h00, 4'h0);
		chk("read data", {24'h0, mdl[s]}, rd);
		chk("read error", 32'h0, {31'h0, err});
	endtask

	task automatic portchk();
		chk("interval", {16'h0, mdl[6], mdl[5]}, {16'h0, wd_int});
		chk("free run", {2'h0, mdl[10][5:0], mdl[9], mdl[8], mdl[7]}, {2'h0, fr_word});
		chk("four level", {31'h0, mdl[11][5]}, {31'h0, four_lvl});
		chk("clamp low", {12'h0, mdl[14][3:0], mdl[13], mdl[12]}, {12'h0, cl_lo});
		chk("clamp high", {12'h0, mdl[17][3:0], mdl[16], mdl[15]}, {12'h0, cl_hi});
	endtask

	task automatic clear_status();
		for (int g = 18; g < 22; g++) begin
			apb(1'b1, clk_xlat_regs_pkg::SLOT_IDX[g], 8'hff, 4'h1);
			mdl[g] = 8'h00;
		end
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// Cycle ceiling cuts a hang short; expiry pulses are counted here
	always @(posedge clk_sys) begin
		cyc++;
		if (watchdog_expired === 1'b1) exp_cnt++;
		if (cyc == 20000) begin
			fail_count++;
			wrap_up();
		end
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb, watchdog_kick} = '0;
		{aux_events, loop_events, limiter_events, reference_events} = '0;
		sys_rst = 1'b1;
		seed = $urandom(32'h2b7a);
		for (int s = 0; s < 22; s++) mdl[s] = clk_xlat_regs_pkg::SLOT_RST[s];
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		portchk();
		for (int s = 0; s < 22; s++) rdchk(s);
		// Random bytes in every config slot; oscillator bit four always written as one
		for (int s = 0; s < 18; s++) wr(s, 8'($urandom()) | (s == 11 ? 8'h10 : 8'h00));
		apb(1'b1, clk_xlat_regs_pkg::SLOT_IDX[0], 8'hff, 4'h0);
		for (int s = 0; s < 18; s++) rdchk(s);
		portchk();
		apb(1'b0, 12'h305, 8'h00, 4'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		// Zero interval stops the watchdog before the event pass
		wr(5, 8'h00);
		wr(6, 8'h00);
		clear_status();
		e0 = exp_cnt;
		chk("irq idle", 32'h0, {31'h0, irq});
		@(posedge clk_sys);
		{aux_events, loop_events, limiter_events, reference_events} <= '1;
		@(posedge clk_sys);
		{aux_events, loop_events, limiter_events, reference_events} <= '0;
		repeat (2) @(posedge clk_sys);
		chk("irq raised", {31'h0, |{mdl[0], mdl[1], mdl[2], mdl[3]}}, {31'h0, irq});
		for (int g = 0; g < 4; g++) mdl[18 + g] = mdl[g];
		for (int g = 18; g < 22; g++) rdchk(g);
		clear_status();
		for (int g = 18; g < 22; g++) rdchk(g);
		repeat (100) @(posedge clk_sys);
		chk("disabled expiry", e0, exp_cnt);
		// Kicks every 11 cycles keep a 2 ms interval from running out
		wr(0, 8'h04);
		wr(5, 8'h02);
		repeat (5) begin
			repeat (10) @(posedge clk_sys);
			watchdog_kick <= 1'b1;
			@(posedge clk_sys);
			watchdog_kick <= 1'b0;
		end
		chk("kicked expiry", e0, exp_cnt);
		for (n = 0; n < 60 && exp_cnt == e0; n++) @(posedge clk_sys);
		chk("expiry count", e0 + 1, exp_cnt);
		chk("expiry time", 32'h1, {31'h0, n >= 17 && n <= 23});
		wr(5, 8'h00);
		mdl[18] = 8'h04;
		rdchk(18);
		chk("irq watchdog", 32'h1, {31'h0, irq});
		clear_status();
		chk("irq cleared", 32'h0, {31'h0, irq});
		wrap_up();
	end
endmodule
`default_nettype wire
